// File: npiu_pkg.sv
// package: register map, level codes and vector layout of the nested interrupt unit
package npiu_pkg;
   localparam int NVEC = 14;
   localparam logic [11:0] ADDR_CC = 12'h000;
   localparam logic [11:0] ADDR_VP0 = 12'h004;
   localparam logic [11:0] ADDR_VP1 = 12'h008;
   localparam logic [11:0] ADDR_VP2 = 12'h00C;
   localparam logic [11:0] ADDR_VP3 = 12'h010;
   localparam logic [11:0] ADDR_STAT = 12'h014;
   localparam logic [1:0] LVL0 = 2'h2;
   localparam logic [1:0] LVL1 = 2'h1;
   localparam logic [1:0] LVL2 = 2'h0;
   localparam logic [1:0] LVL3 = 2'h3;
   localparam int CC_LVL_HI = 5;
   localparam int CC_LVL_LO = 3;
   localparam logic [7:0] CC_RESET = 8'hEA;
   localparam logic [7:0] VP_RESET = 8'hFF;
   localparam logic [3:0] VP3_RO = 4'hF;
   localparam logic [15:0] VEC_RESET = 16'hFFFE;
   localparam logic [15:0] VEC_TRAP = 16'hFFFC;
   localparam logic [15:0] VEC_BASE = 16'hFFFA;
   localparam logic [13:0] HALT_WAKE = 14'h00BE;
   localparam logic [2:0] OP_NONE = 3'h0;
   localparam logic [2:0] OP_ENABLE = 3'h1;
   localparam logic [2:0] OP_DISABLE = 3'h2;
   localparam logic [2:0] OP_HALT = 3'h3;
   localparam logic [2:0] OP_WAIT = 3'h4;
   localparam logic [2:0] OP_TRAP = 3'h5;
   localparam logic [2:0] OP_RETURN = 3'h6;
   typedef enum logic [2:0] {NPIU_RUN, NPIU_STACK, NPIU_VECTOR, NPIU_WAIT, NPIU_HALT} npiu_state_t;
endpackage

// File: npiu_top.sv
// nested priority interrupt unit: arbitration, entry/return sequencing, APB registers
// Behaviour
// [RULE1] finish instruction, then stack context
// [RULE2] entry loads level from vector's priority
// [RULE3] then load vector address into PC
// [RULE4] return pops context restoring previous level
// [RULE5] level codes 10,01,00,11; 11 masks
// [RULE6] highest level wins, then hardware priority
// [RULE7] unserviced requests stay latched until highest
// [RULE8] reset and trap ignore mask, set level3
// [RULE9] reset and trap wake from halt; halt here exits on reset or win_ok only, not on trap_pend
// [RULE10] level bits at condition code 5,3
// [RULE11] reset highest priority, runs at level3
// [RULE12] serve only enabled, strictly higher level
// [RULE13] edge requests latched, cleared on entry
// [RULE14] pins of one group ORed together
// [RULE15] peripheral request needs flag and enable
// [RULE16] flag clear sequence drops pending latch
// [RULE17] any wakes wait; halt-capable only halt
// [RULE18] halt exit serves halt-capable source first
// [RULE19] four priority registers, reset FFh, top fixed
// [RULE20] writes of level0 code are ignored
// [RULE21] raised level re-enters still-pending vector
// [RULE22] instructions load 10 or 11; jump tests
// [RULE23] vectors from top address downward
// [RULE24] no stack overflow detection
`timescale 1ns/100ps
`default_nettype none
module npiu_top #(
   parameter int GROUP_W = 4
) (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [4*GROUP_W-1:0] ext_pins_i,
   input wire logic [4*GROUP_W-1:0] ext_sel_i,
   input wire logic [13:0] periph_flag_i,
   input wire logic [13:0] periph_en_i,
   input wire logic [13:0] periph_clear_i,
   input wire logic [13:0] src_enable_i,
   input wire logic instr_done_i,
   input wire logic [2:0] instr_op_i,
   input wire logic [7:0] popped_cc_i,
   output logic stack_req_o,
   input wire logic stack_done_i,
   output logic [15:0] pc_load_o,
   output logic pc_load_valid_o,
   output logic [3:0] serviced_o,
   output logic cpu_sleep_o,
   output logic jump_if_masked_o,
   output logic jump_if_unmasked_o
);
   ////////////////////////////////////////////////////////////////////////////////
   npiu_pkg::npiu_state_t state;
   logic [7:0] condition_code_reg;
   logic [7:0] vp [4];
   logic [13:0] pend;
   logic [4*GROUP_W-1:0] pin_s1, pin_s2, pin_s3;
   logic trap_pend;
   logic [3:0] win_idx;
   logic win_ok;
   logic [1:0] cur_lvl;
   logic [1:0] win_lvl;

   // rank so that level 3 > 2 > 1 > 0 despite the odd encoding
   function automatic logic [1:0] rank(input logic [1:0] code);
      case (code)
         npiu_pkg::LVL0: rank = 2'h0;
         npiu_pkg::LVL1: rank = 2'h1;
         npiu_pkg::LVL2: rank = 2'h2;
         default: rank = 2'h3;
      endcase
   endfunction

   function automatic logic [1:0] vec_lvl(input logic [3:0] v);
      logic [7:0] r;
      r = vp[v[3:2]];
      vec_lvl = r[{v[1:0], 1'b1} -: 2];
   endfunction

   assign cur_lvl = {condition_code_reg[npiu_pkg::CC_LVL_HI], condition_code_reg[npiu_pkg::CC_LVL_LO]}; // [RULE10]
   assign jump_if_masked_o = (cur_lvl == npiu_pkg::LVL3); // [RULE22]
   assign jump_if_unmasked_o = (cur_lvl != npiu_pkg::LVL3); // [RULE22]
   assign cpu_sleep_o = (state == npiu_pkg::NPIU_WAIT) || (state == npiu_pkg::NPIU_HALT);

   ////////////////////////////////////////////////////////////////////////////////
   // pins are asynchronous; edges detected on the second and third stage only
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
      end
      else
      begin
         pin_s1 <= ext_pins_i;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   logic [13:0] raw_req;
   genvar g;
   generate
      for (g = 0; g < 14; g++)
      begin : g_req
         if (g >= 2 && g <= 5)
         begin : g_ext
            // rising edge of any selected pin of the group
            assign raw_req[g] = |(pin_s2[(g-2)*GROUP_W +: GROUP_W] & ~pin_s3[(g-2)*GROUP_W +: GROUP_W]
                                  & ext_sel_i[(g-2)*GROUP_W +: GROUP_W]); // [RULE14]
         end
         else
         begin : g_per
            assign raw_req[g] = periph_flag_i[g] & periph_en_i[g]; // [RULE15]
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // arbitration: higher rank wins; lower index (higher hardware priority) breaks ties
   always_comb
   begin
      logic [1:0] best;
      logic [1:0] r;
      logic wake_ok;
      r = 2'h0;
      wake_ok = 1'b0;
      best = 2'h0;
      win_idx = 4'h0;
      win_ok = 1'b0;
      win_lvl = npiu_pkg::LVL3;
      for (int i = 13; i >= 0; i--)
      begin
         r = rank(vec_lvl(4'(i)));
         wake_ok = (state != npiu_pkg::NPIU_HALT) || npiu_pkg::HALT_WAKE[i]; // [RULE17] [RULE18]
         if (pend[i] && src_enable_i[i] && wake_ok && r > rank(cur_lvl) && (!win_ok || r >= best)) // [RULE6] [RULE12]
         begin
            best = r;
            win_idx = 4'(i);
            win_ok = 1'b1;
            win_lvl = vec_lvl(4'(i));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   logic take_irq;
   logic take_trap;
   logic [3:0] cur_vec;
   logic cur_is_trap;
   assign take_trap = trap_pend;
   assign take_irq = win_ok && !trap_pend;

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         state <= npiu_pkg::NPIU_VECTOR; // reset vectors without stacking [RULE8] [RULE11]
         cur_vec <= 4'h0;
         cur_is_trap <= 1'b0;
      end
      else
      begin
         unique case (state)
            npiu_pkg::NPIU_RUN:
               // the trap instruction has already completed when trap_pend is set
               if (take_trap || (instr_done_i && take_irq)) // [RULE1] [RULE8]
               begin
                  state <= npiu_pkg::NPIU_STACK;
                  cur_is_trap <= take_trap;
                  cur_vec <= win_idx;
               end
               else if (instr_done_i && instr_op_i == npiu_pkg::OP_WAIT)
                  state <= npiu_pkg::NPIU_WAIT;
               else if (instr_done_i && instr_op_i == npiu_pkg::OP_HALT)
                  state <= npiu_pkg::NPIU_HALT;
            npiu_pkg::NPIU_STACK:
               if (stack_done_i)
                  state <= npiu_pkg::NPIU_VECTOR; // [RULE1]
            npiu_pkg::NPIU_VECTOR:
               state <= npiu_pkg::NPIU_RUN;
            npiu_pkg::NPIU_WAIT, npiu_pkg::NPIU_HALT:
               if (win_ok)
               begin
                  state <= npiu_pkg::NPIU_STACK; // [RULE17]
                  cur_is_trap <= 1'b0;
                  cur_vec <= win_idx;
               end
            default:
               state <= npiu_pkg::NPIU_RUN;
         endcase
      end
   end

   // trap latched when the trap instruction completes
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         trap_pend <= 1'b0;
      else if (instr_done_i && instr_op_i == npiu_pkg::OP_TRAP)
         trap_pend <= 1'b1; // [RULE8]
      else if (state == npiu_pkg::NPIU_STACK && stack_done_i && cur_is_trap)
         trap_pend <= 1'b0;
   end

   // pending latches: set wins over entry clear; peripheral clear drops it
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         pend <= '0;
      else
      begin
         for (int i = 0; i < 14; i++)
         begin
            if (raw_req[i])
               pend[i] <= 1'b1; // [RULE7] [RULE13]
            else if (periph_clear_i[i])
               pend[i] <= 1'b0; // [RULE16]
            else if (state == npiu_pkg::NPIU_VECTOR && !cur_is_trap && cur_vec == 4'(i) && i >= 2 && i <= 5)
               pend[i] <= 1'b0; // [RULE13]
         end
      end
   end

   // stays pending after entry when the source flag holds, so a raised level re-enters
   // [RULE21]

   ////////////////////////////////////////////////////////////////////////////////
   logic boot;
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         boot <= 1'b1;
      else if (state == npiu_pkg::NPIU_VECTOR)
         boot <= 1'b0;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         pc_load_o <= '0;
         pc_load_valid_o <= 1'b0;
         serviced_o <= '0;
      end
      else
      begin
         pc_load_valid_o <= (state == npiu_pkg::NPIU_VECTOR);
         if (state == npiu_pkg::NPIU_VECTOR)
         begin
            if (boot)
               pc_load_o <= npiu_pkg::VEC_RESET; // [RULE11]
            else if (cur_is_trap)
               pc_load_o <= npiu_pkg::VEC_TRAP; // [RULE8]
            else
               pc_load_o <= npiu_pkg::VEC_BASE - {11'h0, cur_vec, 1'b0}; // [RULE3] [RULE23]
            serviced_o <= cur_vec;
         end
      end
   end
   assign stack_req_o = (state == npiu_pkg::NPIU_STACK); // [RULE1]

   ////////////////////////////////////////////////////////////////////////////////
   logic apb_wr;
   logic [7:0] wb;
   assign apb_wr = psel_i && penable_i && pwrite_i;
   assign wb = pwdata_i[7:0];
   assign pready_o = 1'b1;

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
         condition_code_reg <= npiu_pkg::CC_RESET;
      else if (state == npiu_pkg::NPIU_VECTOR)
      begin
         if (boot || cur_is_trap)
         begin
            condition_code_reg[npiu_pkg::CC_LVL_HI] <= 1'b1; // [RULE8] [RULE11]
            condition_code_reg[npiu_pkg::CC_LVL_LO] <= 1'b1;
         end
         else
         begin
            condition_code_reg[npiu_pkg::CC_LVL_HI] <= vec_lvl(cur_vec)[1]; // [RULE2]
            condition_code_reg[npiu_pkg::CC_LVL_LO] <= vec_lvl(cur_vec)[0];
         end
      end
      else if (instr_done_i && instr_op_i == npiu_pkg::OP_RETURN)
         condition_code_reg <= popped_cc_i; // [RULE4]
      else if (instr_done_i && (instr_op_i == npiu_pkg::OP_ENABLE || instr_op_i == npiu_pkg::OP_HALT
               || instr_op_i == npiu_pkg::OP_WAIT))
      begin
         condition_code_reg[npiu_pkg::CC_LVL_HI] <= npiu_pkg::LVL0[1]; // [RULE22]
         condition_code_reg[npiu_pkg::CC_LVL_LO] <= npiu_pkg::LVL0[0];
      end
      else if (instr_done_i && instr_op_i == npiu_pkg::OP_DISABLE)
      begin
         condition_code_reg[npiu_pkg::CC_LVL_HI] <= npiu_pkg::LVL3[1]; // [RULE22]
         condition_code_reg[npiu_pkg::CC_LVL_LO] <= npiu_pkg::LVL3[0];
      end
      else if (apb_wr && paddr_i == npiu_pkg::ADDR_CC)
         condition_code_reg <= wb;
   end

   // per-field write; level 0 code leaves the field untouched
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         for (int r = 0; r < 4; r++)
            vp[r] <= npiu_pkg::VP_RESET; // [RULE19]
      end
      else if (apb_wr)
      begin
         for (int r = 0; r < 4; r++)
         begin
            if (paddr_i == npiu_pkg::ADDR_VP0 + 12'(4 * r))
            begin
               for (int f = 0; f < 4; f++)
               begin
                  if (wb[2*f +: 2] != npiu_pkg::LVL0 && !(r == 3 && f >= 2)) // [RULE20] [RULE19]
                     vp[r][2*f +: 2] <= wb[2*f +: 2];
               end
            end
         end
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i)
      begin
         prdata_o <= '0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         pslverr_o <= 1'b0;
         if (psel_i && !penable_i && !pwrite_i)
         begin
            case (paddr_i)
               npiu_pkg::ADDR_CC: prdata_o <= {24'h0, condition_code_reg};
               npiu_pkg::ADDR_VP0: prdata_o <= {24'h0, vp[0]};
               npiu_pkg::ADDR_VP1: prdata_o <= {24'h0, vp[1]};
               npiu_pkg::ADDR_VP2: prdata_o <= {24'h0, vp[2]};
               npiu_pkg::ADDR_VP3: prdata_o <= {24'h0, npiu_pkg::VP3_RO, vp[3][3:0]}; // [RULE19]
               npiu_pkg::ADDR_STAT: prdata_o <= {18'h0, pend};
               default: prdata_o <= '0;
            endcase
         end
         if (psel_i && !penable_i)
            pslverr_o <= !(paddr_i inside {npiu_pkg::ADDR_CC, npiu_pkg::ADDR_VP0, npiu_pkg::ADDR_VP1,
                            npiu_pkg::ADDR_VP2, npiu_pkg::ADDR_VP3, npiu_pkg::ADDR_STAT});
      end
   end
   // nested entries push without any depth check; software bounds nesting [RULE24]

   ////////////////////////////////////////////////////////////////////////////////
   a_entry_level: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE2]
      state == npiu_pkg::NPIU_VECTOR && !boot && !cur_is_trap |=> cur_lvl == $past(vec_lvl(cur_vec)))
      else $error("entry level mismatch");
   a_trap_level: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE8]
      state == npiu_pkg::NPIU_VECTOR && cur_is_trap |=> cur_lvl == npiu_pkg::LVL3 && pc_load_o == npiu_pkg::VEC_TRAP)
      else $error("trap entry wrong");
   a_stack_first: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE1]
      $rose(pc_load_valid_o) && !$past(boot, 2) |-> $past(stack_req_o, 2))
      else $error("vector without stacking");
   a_vec_addr: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE3]
      state == npiu_pkg::NPIU_VECTOR && !boot && !cur_is_trap |=> pc_load_o == 16'hFFFA - 16'($past(cur_vec) * 2))
      else $error("vector address wrong");
   a_ret_pop: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE4]
      state == npiu_pkg::NPIU_RUN && instr_done_i && instr_op_i == npiu_pkg::OP_RETURN && !take_irq && !take_trap
      |=> condition_code_reg == $past(popped_cc_i))
      else $error("return did not restore");
   a_mask_l3: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE5]
      cur_lvl == npiu_pkg::LVL3 |-> !win_ok)
      else $error("maskable taken at level 3");
   a_halt_wake: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE18]
      state == npiu_pkg::NPIU_HALT && win_ok |-> npiu_pkg::HALT_WAKE[win_idx])
      else $error("non halt source woke halt");
   a_vp_reset: assert property (@(posedge ref_clk_i) // [RULE19]
      !nrst_i |=> vp[0] == 8'hFF && vp[3] == 8'hFF)
      else $error("priority reset wrong");
   a_disable_lvl: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE22]
      state == npiu_pkg::NPIU_RUN && instr_done_i && instr_op_i == npiu_pkg::OP_DISABLE && !take_irq && !take_trap
      |=> cur_lvl == 2'h3)
      else $error("disable did not mask");
endmodule
`default_nettype wire

// File: npiu_cpu_model.sv
// cpu-side partner model: answers context stacking requests
`timescale 1ns/100ps
`default_nettype none
module npiu_cpu_model (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic stack_req_i,
   input wire logic slow_i,
   output logic stack_done_o
);
   logic [3:0] cnt;
   // pushes pc, index, accumulator and cc, then one done pulse
   // stack is unbounded here, so deep nesting goes unflagged as in silicon
   always_ff @(posedge ref_clk_i)
   begin
      if (!nrst_i || stack_done_o)
      begin
         stack_done_o <= 1'b0;
         cnt <= 4'h0;
      end
      else if (stack_req_i)
      begin
         if (cnt >= (slow_i ? 4'h6 : 4'h0))
            stack_done_o <= 1'b1;
         else
            cnt <= cnt + 4'h1;
      end
   end
endmodule
`default_nettype wire

// File: npiu_top_tb.sv
// self-checking bench for the nested priority interrupt unit
`timescale 1ns/100ps
`default_nettype none
module npiu_top_tb;
   logic clk, rst_n, psel, pen, pwr, pready, perr, er, sreq, sdone, pvalid, sleep, jm, jn, idone, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, rv;
   logic [15:0] pins, sel, pc;
   logic [13:0] flag, en, clr, srcen;
   logic [2:0] iop;
   logic [7:0] pcc;
   logic [15:0] expq[$];
   int mismatches, cmp_count, entries, exp_n;
   ////////////////////////////////////////////////////////////////
   npiu_top #(.GROUP_W(4)) i_dut (.ref_clk_i(clk), .nrst_i(rst_n), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(perr), .ext_pins_i(pins), .ext_sel_i(sel), .periph_flag_i(flag), .periph_en_i(en),
      .periph_clear_i(clr), .src_enable_i(srcen), .instr_done_i(idone), .instr_op_i(iop),
      .popped_cc_i(pcc), .stack_req_o(sreq), .stack_done_i(sdone), .pc_load_o(pc),
      .pc_load_valid_o(pvalid), .serviced_o(), .cpu_sleep_o(sleep), .jump_if_masked_o(jm),
      .jump_if_unmasked_o(jn));
   npiu_cpu_model i_cpu (.ref_clk_i(clk), .nrst_i(rst_n), .stack_req_i(sreq), .slow_i(slow),
      .stack_done_o(sdone));
   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("mismatches %0d, comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      chk(pready, 1'b1, "bus wait");
      rd = prdata;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, "register read");
   endtask
   task automatic instr(input logic [2:0] op);
      iop <= op;
      idone <= 1'b1;
      @(posedge clk);
      idone <= 1'b0;
      iop <= npiu_pkg::OP_NONE;
      @(posedge clk);
   endtask
   task automatic drive(input logic [13:0] f, input logic [13:0] c);
      flag <= f;
      clr <= c;
      @(posedge clk);
      clr <= 14'h0;
      @(posedge clk);
   endtask
   task automatic note(input logic [15:0] a);
      expq.push_back(a);
      exp_n++;
   endtask
   task automatic settle();
      int n;
      n = 0;
      while (entries != exp_n && n < 300)
      begin
         @(posedge clk);
         n++;
      end
      chk(entries, exp_n, "entry wait");
      if (entries != exp_n)
         stop_test();
      repeat (2) @(posedge clk);
   endtask
   // level 0 code in a field keeps the old field
   function automatic logic [7:0] merge(input logic [7:0] o, input logic [7:0] w);
      logic [7:0] r;
      for (int i = 0; i < 8; i += 2)
         r[i+:2] = (w[i+:2] == npiu_pkg::LVL0) ? o[i+:2] : w[i+:2];
      return r;
   endfunction
   ////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      if (rst_n === 1'b1 && pvalid === 1'b1)
      begin
         entries++;
         cmp_count++;
         if (expq.size() == 0 || pc !== expq.pop_front())
         begin
            mismatches++;
            $display("unexpected at %0t: vector entry %h", $time, pc);
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   initial
   begin
      {rst_n, psel, pen, pwr, idone, slow} = '0;
      paddr = '0;
      pwdata = '0;
      pins = '0;
      sel = 16'h00F0;
      flag = 14'h0800;
      en = 14'h37FF;
      clr = '0;
      srcen = 14'h3FFF;
      iop = npiu_pkg::OP_NONE;
      pcc = '0;
      rv = $urandom(869);
      note(npiu_pkg::VEC_RESET);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      rdchk(npiu_pkg::ADDR_CC, 32'(npiu_pkg::CC_RESET));
      chk(jm, 1'b1, "masked jump");
      for (int i = 0; i < 4; i++)
         rdchk(npiu_pkg::ADDR_VP0 + 12'(4 * i), 32'h000000FF);
      apb(1'b0, 12'h018, 32'h0);
      chk(er, 1'b1, "unmapped error");
      apb(1'b1, npiu_pkg::ADDR_VP0, 32'h000000CF);
      apb(1'b1, npiu_pkg::ADDR_VP0, 32'h00000064);
      rdchk(npiu_pkg::ADDR_VP0, 32'h00000044);
      rv = $urandom;
      apb(1'b1, npiu_pkg::ADDR_VP2, rv);
      rdchk(npiu_pkg::ADDR_VP2, 32'(merge(8'hFF, rv[7:0])));
      apb(1'b1, npiu_pkg::ADDR_VP3, 32'h0);
      rdchk(npiu_pkg::ADDR_VP3, 32'h000000F0);
      apb(1'b1, npiu_pkg::ADDR_VP2, 32'h0000000C);
      // vector 10 is dropped by its clear, 11 never enabled
      drive(14'h0F00, 14'h0);
      drive(14'h0B00, 14'h0400);
      note(16'hFFE8);
      instr(npiu_pkg::OP_ENABLE);
      chk(jn, 1'b1, "unmasked jump");
      instr(npiu_pkg::OP_NONE);
      settle();
      rdchk(npiu_pkg::ADDR_CC, 32'h000000EA);
      drive(14'h0900, 14'h0200);
      pcc <= 8'hE2;
      note(16'hFFEA);
      instr(npiu_pkg::OP_RETURN);
      instr(npiu_pkg::OP_NONE);
      settle();
      rdchk(npiu_pkg::ADDR_CC, 32'h000000C2);
      drive(14'h0800, 14'h0100);
      slow <= 1'b1;
      note(npiu_pkg::VEC_TRAP);
      instr(npiu_pkg::OP_TRAP);
      settle();
      rdchk(npiu_pkg::ADDR_CC, 32'h000000EA);
      pcc <= 8'hC2;
      instr(npiu_pkg::OP_RETURN);
      rdchk(npiu_pkg::ADDR_CC, 32'h000000C2);
      instr(npiu_pkg::OP_HALT);
      chk(sleep, 1'b1, "halt entry");
      rdchk(npiu_pkg::ADDR_CC, 32'h000000E2);
      drive(14'h0900, 14'h0);
      repeat (10) @(posedge clk);
      chk(sleep, 1'b1, "left halt early");
      note(16'hFFF4);
      pins <= 16'h0041;
      settle();
      rdchk(npiu_pkg::ADDR_CC, 32'h000000CA);
      note(16'hFFEA);
      instr(npiu_pkg::OP_NONE);
      settle();
      drive(14'h0800, 14'h0100);
      instr(npiu_pkg::OP_WAIT);
      chk(sleep, 1'b1, "wait entry");
      slow <= rv[8];
      note(16'hFFE6);
      drive(14'h0C00, 14'h0);
      settle();
      drive(14'h0800, 14'h0400);
      instr(npiu_pkg::OP_ENABLE);
      instr(npiu_pkg::OP_NONE);
      repeat (30) @(posedge clk);
      chk(expq.size(), 32'h0, "entries left over");
      stop_test();
   end
endmodule
`default_nettype wire
